// ---- include/pfm_pkg.sv ----
// Behaviour
// - Open-drain select bit 1 gives open-drain pin, 0 push-pull; resets 0.
// - Pin 7 is channel 4 transmit when enabled, else general I/O by direction.
// - Pin 6 is channel 4 receive input when enabled, else general I/O.
// - Pin 5 gives channel 1/4 clock in/out per clock enables; interrupt 5 sensed.
// - Pin 4 is channel 1 receive input when enabled, else general I/O.
// - Pin 3 is channel 1 transmit when enabled, else general I/O.
// - Pin 2 gives channel 0 clock in/out per clock enables; interrupt 4 sensed.
// - Open-drain select on pin 5 or 2 also makes serial clock open-drain.
// - Pin 1 is channel 0 receive input when enabled, else general I/O.
// - Pin 0 is channel 0 transmit when enabled, else general I/O.
// - General output with open-drain select drives only low, else releases.
// - Direction 1 output, 0 input; write-only, resets 0, reads undefined.
// - Data register holds general output values; resets 0.
// - State read gives data bit where direction 1, pin level otherwise.
package pfm_pkg;
    localparam int PFM_ADDR_W = 4;
    localparam int PFM_PORT_W = 8;

    localparam logic [3:0] PFM_DIR_OFS   = 4'h0;
    localparam logic [3:0] PFM_DATA_OFS  = 4'h1;
    localparam logic [3:0] PFM_STATE_OFS = 4'h2;
    localparam logic [3:0] PFM_ODSEL_OFS = 4'h3;

    localparam logic [7:0] PFM_DIR_RST   = 8'h00;
    localparam logic [7:0] PFM_DATA_RST  = 8'h00;
    localparam logic [7:0] PFM_ODSEL_RST = 8'h00;
    localparam logic [7:0] PFM_DIR_RDVAL = 8'h00;

    localparam int PFM_PIN_CH0_TX  = 0;
    localparam int PFM_PIN_CH0_RX  = 1;
    localparam int PFM_PIN_CH0_CLK = 2;
    localparam int PFM_PIN_CH1_TX  = 3;
    localparam int PFM_PIN_CH1_RX  = 4;
    localparam int PFM_PIN_CH14_CLK = 5;
    localparam int PFM_PIN_CH4_RX  = 6;
    localparam int PFM_PIN_CH4_TX  = 7;
endpackage

// ---- logic/pfm_pin_cell.sv ----
`timescale 1ns/10ps
module pfm_pin_cell
    import pfm_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic drive_en,
    input  wire logic drive_val,
    input  wire logic open_drain,
    output logic      pin_out,
    output logic      pin_oe
);
    wire logic out_nxt;
    wire logic oe_nxt;

    // Open drain: only low is driven, high releases the pin
    assign out_nxt = open_drain ? 1'b0 : drive_val;
    assign oe_nxt  = drive_en & (~open_drain | ~drive_val);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            pin_out <= out_nxt;
            pin_oe  <= oe_nxt;
        end
    end
endmodule

// ---- logic/pfm_port_mux.sv ----
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
module pfm_port_mux
    import pfm_pkg::*;
(
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire logic [PFM_ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    input  wire logic                  ch0_transmit_enable,
    input  wire logic                  ch0_receive_enable,
    input  wire logic                  ch0_clock_enable_low,
    input  wire logic                  ch0_clock_enable_high,
    input  wire logic                  ch0_sync_mode,
    input  wire logic                  ch0_transmit_out,
    input  wire logic                  ch0_serial_clock_out,
    input  wire logic                  ch1_transmit_enable,
    input  wire logic                  ch1_receive_enable,
    input  wire logic                  ch1_clock_enable_low,
    input  wire logic                  ch1_clock_enable_high,
    input  wire logic                  ch1_sync_mode,
    input  wire logic                  ch1_transmit_out,
    input  wire logic                  ch1_serial_clock_out,
    input  wire logic                  ch4_transmit_enable,
    input  wire logic                  ch4_receive_enable,
    input  wire logic                  ch4_clock_enable_low,
    input  wire logic                  ch4_clock_enable_high,
    input  wire logic                  ch4_sync_mode,
    input  wire logic                  ch4_transmit_out,
    input  wire logic                  ch4_serial_clock_out,
    output logic                       ch0_receive_in,
    output logic                       ch0_serial_clock,
    output logic                       ch1_receive_in,
    output logic                       ch1_serial_clock,
    output logic                       ch4_receive_in,
    output logic                       ch4_serial_clock,
    output logic                       ext_interrupt_4,
    output logic                       ext_interrupt_5,
    input  wire logic [PFM_PORT_W-1:0] pin_in,
    output logic      [PFM_PORT_W-1:0] pin_out,
    output logic      [PFM_PORT_W-1:0] pin_oe
);
    // Clock pin drives out: external clock not enabled, and internal clock enabled or synchronous mode
    function automatic logic clk_drives(input logic clock_enable_low, input logic clock_enable_high,
                                        input logic sync);
        clk_drives = ~clock_enable_high & (clock_enable_low | sync);
    endfunction

    logic [7:0] port_direction_reg_r;
    logic [7:0] port_output_value_reg_r;
    logic [7:0] port_open_drain_select_r;
    logic [7:0] rdata_nxt;

    wire logic       wr_dir;
    wire logic       wr_data;
    wire logic       wr_odsel;
    wire logic [7:0] state_view;
    wire logic       ch0_clk_out;
    wire logic       ch1_clk_out;
    wire logic       ch4_clk_out;
    wire logic       ch14_clk_out;
    wire logic       ch0_clk_in;
    wire logic       ch14_clk_in;
    wire logic [7:0] serial_drive;
    wire logic [7:0] serial_owns;
    wire logic [7:0] serial_val;
    wire logic [7:0] drive_en;
    wire logic [7:0] drive_val;

    assign wr_dir   = reg_wr && (reg_addr == PFM_DIR_OFS);
    assign wr_data  = reg_wr && (reg_addr == PFM_DATA_OFS);
    assign wr_odsel = reg_wr && (reg_addr == PFM_ODSEL_OFS);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_direction_reg_r <= PFM_DIR_RST;
        end else if (wr_dir) begin
            port_direction_reg_r <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_output_value_reg_r <= PFM_DATA_RST;
        end else if (wr_data) begin
            port_output_value_reg_r <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            port_open_drain_select_r <= PFM_ODSEL_RST;
        end else if (wr_odsel) begin
            port_open_drain_select_r <= reg_wdata;
        end
    end

    // Pin-state view: output data for outputs, live level for inputs
    assign state_view = (port_direction_reg_r & port_output_value_reg_r)
                      | (~port_direction_reg_r & pin_in);

    always_comb begin
        rdata_nxt = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                PFM_DIR_OFS:   rdata_nxt = PFM_DIR_RDVAL;
                PFM_DATA_OFS:  rdata_nxt = port_output_value_reg_r;
                PFM_STATE_OFS: rdata_nxt = state_view;
                PFM_ODSEL_OFS: rdata_nxt = port_open_drain_select_r;
                default:       rdata_nxt = 8'h00;
            endcase
        end
    end

    // Clock pin decoding for channel 0 and shared channel 1/4 pin
    assign ch0_clk_out  = clk_drives(ch0_clock_enable_low,
                                     ch0_clock_enable_high,
                                     ch0_sync_mode);
    assign ch1_clk_out  = clk_drives(ch1_clock_enable_low,
                                     ch1_clock_enable_high,
                                     ch1_sync_mode);
    assign ch4_clk_out  = clk_drives(ch4_clock_enable_low,
                                     ch4_clock_enable_high,
                                     ch4_sync_mode);
    assign ch14_clk_out = ch1_clk_out | ch4_clk_out;
    assign ch0_clk_in   = ch0_clock_enable_high;
    assign ch14_clk_in  = ch1_clock_enable_high
                        | ch4_clock_enable_high;

    // Pins taken by a serial channel driving out
    assign serial_drive[PFM_PIN_CH0_TX]   = ch0_transmit_enable;
    assign serial_drive[PFM_PIN_CH0_RX]   = 1'b0;
    assign serial_drive[PFM_PIN_CH0_CLK]  = ch0_clk_out;
    assign serial_drive[PFM_PIN_CH1_TX]   = ch1_transmit_enable;
    assign serial_drive[PFM_PIN_CH1_RX]   = 1'b0;
    assign serial_drive[PFM_PIN_CH14_CLK] = ch14_clk_out;
    assign serial_drive[PFM_PIN_CH4_RX]   = 1'b0;
    assign serial_drive[PFM_PIN_CH4_TX]   = ch4_transmit_enable;

    // Pins taken by a serial channel as an input
    assign serial_owns[PFM_PIN_CH0_TX]   = 1'b0;
    assign serial_owns[PFM_PIN_CH0_RX]   = ch0_receive_enable;
    assign serial_owns[PFM_PIN_CH0_CLK]  = ch0_clk_in;
    assign serial_owns[PFM_PIN_CH1_TX]   = 1'b0;
    assign serial_owns[PFM_PIN_CH1_RX]   = ch1_receive_enable;
    assign serial_owns[PFM_PIN_CH14_CLK] = ch14_clk_in;
    assign serial_owns[PFM_PIN_CH4_RX]   = ch4_receive_enable;
    assign serial_owns[PFM_PIN_CH4_TX]   = 1'b0;

    // Channel 1 wins should both clocks be enabled on the shared pin
    assign serial_val[PFM_PIN_CH0_TX]   = ch0_transmit_out;
    assign serial_val[PFM_PIN_CH0_RX]   = 1'b0;
    assign serial_val[PFM_PIN_CH0_CLK]  = ch0_serial_clock_out;
    assign serial_val[PFM_PIN_CH1_TX]   = ch1_transmit_out;
    assign serial_val[PFM_PIN_CH1_RX]   = 1'b0;
    assign serial_val[PFM_PIN_CH14_CLK] = ch1_clk_out ?
                                          ch1_serial_clock_out :
                                          ch4_serial_clock_out;
    assign serial_val[PFM_PIN_CH4_RX]   = 1'b0;
    assign serial_val[PFM_PIN_CH4_TX]   = ch4_transmit_out;

    genvar gi;
    generate
        for (gi = 0; gi < PFM_PORT_W; gi++) begin : g_pin
            // Serial output overrides; else direction picks general I/O
            assign drive_en[gi]  = serial_drive[gi] |
                                   (~serial_owns[gi] &
                                    port_direction_reg_r[gi]);
            assign drive_val[gi] = serial_drive[gi] ? serial_val[gi] :
                                   port_output_value_reg_r[gi];
            // Open-drain applies to serial and general outputs alike
            pfm_pin_cell u_cell (
                .ref_clk    (ref_clk),
                .nrst       (nrst),
                .drive_en   (drive_en[gi]),
                .drive_val  (drive_val[gi]),
                .open_drain (port_open_drain_select_r[gi]),
                .pin_out    (pin_out[gi]),
                .pin_oe     (pin_oe[gi])
            );
        end
    endgenerate

    // Read data stand one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= rdata_nxt;
        end
    end

    // Receivers idle high until the pins are sensed
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ch0_receive_in <= 1'b1;
        end else begin
            ch0_receive_in <= pin_in[PFM_PIN_CH0_RX];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ch1_receive_in <= 1'b1;
        end else begin
            ch1_receive_in <= pin_in[PFM_PIN_CH1_RX];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ch4_receive_in <= 1'b1;
        end else begin
            ch4_receive_in <= pin_in[PFM_PIN_CH4_RX];
        end
    end

    // Clock pins always follow the pin level
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ch0_serial_clock <= 1'b0;
        end else begin
            ch0_serial_clock <= pin_in[PFM_PIN_CH0_CLK];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ch1_serial_clock <= 1'b0;
        end else begin
            ch1_serial_clock <= pin_in[PFM_PIN_CH14_CLK];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ch4_serial_clock <= 1'b0;
        end else begin
            ch4_serial_clock <= pin_in[PFM_PIN_CH14_CLK];
        end
    end

    // Interrupt inputs are sensed whatever the pin function
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ext_interrupt_4 <= 1'b0;
        end else begin
            ext_interrupt_4 <= pin_in[PFM_PIN_CH0_CLK];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ext_interrupt_5 <= 1'b0;
        end else begin
            ext_interrupt_5 <= pin_in[PFM_PIN_CH14_CLK];
        end
    end
endmodule

// ---- bench/pfm_pin_model.sv ----
`timescale 1ns/10ps
module pfm_pin_model (
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] ext_oe,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pin_level
);
    // Released pins sit at the pull-up unless the board pulls them low
    assign pin_level = (pin_oe & pin_out)
                     | (~pin_oe & ~(ext_oe & ~ext_val));
endmodule

// ---- bench/pfm_port_mux_monitor.sv ----
`timescale 1ns/10ps
module pfm_port_mux_monitor
    import pfm_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       ch0_transmit_enable,
    input wire logic       ch0_transmit_out,
    input wire logic       ch4_receive_enable,
    input wire logic       ext_interrupt_4,
    input wire logic       ext_interrupt_5,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe
);
    // Mirror of the writable registers
    logic [7:0] dir_m, dat_m, od_m;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            {dir_m, dat_m, od_m} <= 24'h000000;
        end else if (reg_wr) begin
            if (reg_addr == PFM_DIR_OFS) dir_m <= reg_wdata;
            if (reg_addr == PFM_DATA_OFS) dat_m <= reg_wdata;
            if (reg_addr == PFM_ODSEL_OFS) od_m <= reg_wdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_tx0; ch0_transmit_enable && !od_m[0] |=>
        pin_oe[0] && pin_out[0] == $past(ch0_transmit_out); endproperty
    a_tx0: assert property (p_tx0) else $error("pin 0 tx wrong");
    property p_od; ($past(od_m) & pin_out) == 8'h00; endproperty
    a_od: assert property (p_od) else $error("od pin high");
    property p_gen6; !ch4_receive_enable && dir_m[6] && !od_m[6] |=>
        pin_oe[6] && pin_out[6] == $past(dat_m[6]); endproperty
    a_gen6: assert property (p_gen6) else $error("pin 6 out");
    property p_rx6; ch4_receive_enable |=> !pin_oe[6]; endproperty
    a_rx6: assert property (p_rx6) else $error("pin 6 driven");
    property p_state; reg_rd && reg_addr == PFM_STATE_OFS |=> reg_rdata ==
        (($past(dir_m) & $past(dat_m)) | (~$past(dir_m) & $past(pin_in)));
    endproperty
    a_state: assert property (p_state) else $error("state read");
    property p_dir; reg_rd && reg_addr == PFM_DIR_OFS |=>
        reg_rdata == PFM_DIR_RDVAL; endproperty
    a_dir: assert property (p_dir) else $error("direction read");
    property p_odrd; reg_rd && reg_addr == PFM_ODSEL_OFS |=>
        reg_rdata == $past(od_m); endproperty
    a_odrd: assert property (p_odrd) else $error("odsel read");
    property p_irq; 1'b1 |=> {ext_interrupt_5, ext_interrupt_4} ==
        {$past(pin_in[5]), $past(pin_in[2])}; endproperty
    a_irq: assert property (p_irq) else $error("irq sense");
    c_tx: cover property (ch0_transmit_enable ##1 pin_oe[0]);
    c_od: cover property (|(od_m & pin_oe));
    c_rx: cover property (ch4_receive_enable ##1 !pin_oe[6]);
endmodule
bind pfm_port_mux pfm_port_mux_monitor u_mon (.ref_clk(ref_clk),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ch0_transmit_enable(ch0_transmit_enable),
    .ch0_transmit_out(ch0_transmit_out), .pin_in(pin_in),
    .ch4_receive_enable(ch4_receive_enable), .pin_oe(pin_oe),
    .ext_interrupt_4(ext_interrupt_4), .ext_interrupt_5(ext_interrupt_5),
    .pin_out(pin_out));

// ---- bench/tb_pfm_port_mux.sv ----
`timescale 1ns/10ps
module tb_pfm_port_mux
    import pfm_pkg::*;
;
    logic        ref_clk, nrst, reg_wr, reg_rd;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, pin_in, pin_out, pin_oe, eo, ev;
    logic [20:0] ctl;
    wire  [7:0]  rx;
    int          error_cnt, cmp_count, seed;
    pfm_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_oe(eo),
        .ext_val(ev), .pin_level(pin_in));
    pfm_port_mux uut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .ch0_transmit_enable(ctl[0]),
        .ch0_receive_enable(ctl[1]), .ch0_clock_enable_low(ctl[2]),
        .ch0_clock_enable_high(ctl[3]), .ch0_sync_mode(ctl[4]),
        .ch0_transmit_out(ctl[5]), .ch0_serial_clock_out(ctl[6]),
        .ch1_transmit_enable(ctl[7]), .ch1_receive_enable(ctl[8]),
        .ch1_clock_enable_low(ctl[9]), .ch1_clock_enable_high(ctl[10]),
        .ch1_sync_mode(ctl[11]), .ch1_transmit_out(ctl[12]),
        .ch1_serial_clock_out(ctl[13]), .ch4_transmit_enable(ctl[14]),
        .ch4_receive_enable(ctl[15]), .ch4_clock_enable_low(ctl[16]),
        .ch4_clock_enable_high(ctl[17]), .ch4_sync_mode(ctl[18]),
        .ch4_transmit_out(ctl[19]), .ch4_serial_clock_out(ctl[20]),
        .ch0_receive_in(rx[0]), .ch0_serial_clock(rx[1]),
        .ch1_receive_in(rx[2]), .ch1_serial_clock(rx[3]),
        .ch4_receive_in(rx[4]), .ch4_serial_clock(rx[5]),
        .ext_interrupt_4(rx[6]), .ext_interrupt_5(rx[7]));
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // Expected {pin_oe, pin_out} from registers and channel controls
    function automatic logic [15:0] exp_pins(input logic [7:0] d, v, o,
                                             input logic [20:0] c);
        logic [7:0] en, val;
        logic [2:0] ck;
        int         tp [3] = '{0, 3, 7};
        int         rp [3] = '{1, 4, 6};
        en = d;
        val = v;
        for (int k = 0; k < 3; k++) begin
            ck[k] = ~c[7*k+3] & (c[7*k+2] | c[7*k+4]);
            if (c[7*k]) val[tp[k]] = c[7*k+5];
            en[tp[k]] = en[tp[k]] | c[7*k];
            en[rp[k]] = en[rp[k]] & ~c[7*k+1];
        end
        en[2] = ck[0] | (~c[3] & d[2]);
        val[2] = ck[0] ? c[6] : v[2];
        // A driving clock on pin 5 wins over the other channel's input
        en[5] = ck[1] | ck[2] | (~(c[10] | c[17]) & d[5]);
        val[5] = ck[1] ? c[13] : ck[2] ? c[20] : v[5];
        return {en & ~(o & val), val & ~o};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, s);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, r, input logic [3:0] a,
                       input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic rd(input string nm, input logic [3:0] a,
                      input logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, a, 8'h00);
        #1 chk(nm, e, reg_rdata);
    endtask
    task automatic run(input logic [7:0] d, v, o, input logic [20:0] c);
        logic [15:0] e;
        if (c[9] | c[11]) c[18:16] = c[18:16] & 3'b010;
        bus(1'b1, 1'b0, PFM_DIR_OFS, d);
        bus(1'b1, 1'b0, PFM_DATA_OFS, v);
        bus(1'b1, 1'b0, PFM_ODSEL_OFS, o);
        bus(1'b1, 1'b0, PFM_STATE_OFS, ~v);
        bus(1'b0, 1'b0, 4'h0, 8'h00);
        ctl <= c;
        eo <= 8'($random(seed));
        ev <= 8'($random(seed));
        repeat (3) @(posedge ref_clk);
        #1 e = exp_pins(d, v, o, c);
        chk("pin_oe", e[15:8], pin_oe);
        chk("pin_out", e[7:0] & e[15:8], pin_out & e[15:8]);
        chk("sense", {pin_in[5], pin_in[2], pin_in[5], pin_in[6], pin_in[5],
            pin_in[4], pin_in[2], pin_in[1]}, rx);
        rd("state", PFM_STATE_OFS, (d & v) | (~d & pin_in));
        rd("odsel", PFM_ODSEL_OFS, o);
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        test_done;
    end
    initial begin
        seed = 32'hC8466FD7;
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata, ctl, eo, ev} = '0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        rd("od_rst", PFM_ODSEL_OFS, PFM_ODSEL_RST);
        rd("state_rst", PFM_STATE_OFS, pin_in);
        rd("dir_read", PFM_DIR_OFS, PFM_DIR_RDVAL);
        rd("unmapped", 4'hF, 8'h00);
        run(8'hFF, 8'hA5, 8'h00, 21'h000000);
        run(8'hFF, 8'h5A, 8'hFF, 21'h000000);
        run(8'hFF, 8'h00, 8'h00, 21'h08D1A3);
        run(8'h00, 8'hFF, 8'h24, 21'h102250);
        run(8'hFF, 8'hFF, 8'h00, 21'h020408);
        run(8'hFF, 8'h00, 8'h00, 21'h110400);
        repeat (300) run(8'($random(seed)), 8'($random(seed)),
            8'($random(seed)), 21'($random(seed)));
        test_done;
    end
endmodule
